// *** core/wetting_current_config.sv ***
// wetting current configuration registers behind a 32-bit spi slave, with per-input timing
//
// Operation
// [RQ1] frame: address in bits 31..25, read/write in bit 24, data in 23..0
// [RQ2] upper ground level register at 0x06, six 3-bit fields from bit 0
// [RQ3] level codes 0..7 mean 2, 6, 8, 10, 12, 14, 16, 20 mA
// [RQ4] every level field resets to code 110, i.e. 16 mA
// [RQ5] each input owns a 20 ms timer started by a comparator crossing
// [RQ6] on timer expiry in pulsed mode current drops to 2.0 mA sustain
// [RQ7] continuous bit 0 gives pulsed wetting, 1 holds wetting level always
// [RQ8] all continuous bits reset to 0, pulsed operation
// [RQ9] battery-input continuous register at 0x0b, bits 7..0 used
// [RQ10] ground-input continuous register at 0x0c, bits 13..0 used
// [RQ11] registers may be rewritten anytime and take effect at once
// [RQ12] unused bits ignore writes and read as zero
`timescale 1ns/1ns
`default_nettype none
module wetting_current_config
   import wetting_pkg::*;
#(
   parameter int WETTING_TICKS = WETTING_TICKS_DEF
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_b_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   input wire logic [GND_INPUTS-1:0] ground_switch_input_cmp_i,
   input wire logic [PROG_INPUTS-1:0] programmable_switch_input_cmp_i,
   output logic [GND_INPUTS-1:0] ground_switch_input_wetting_o,
   output logic [PROG_INPUTS-1:0] programmable_switch_input_wetting_o,
   output logic [UPPER_LEVEL_BITS-1:0] upper_ground_level_o,
   output logic [UPPER_INPUTS*CURRENT_W-1:0] upper_ground_current_o
);
   wetting_timer_if tmr_if ();

   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync3_q;
   logic [SYNC_W-1:0] stable_q;
   logic [SYNC_W-1:0] stable_d;
   logic [ALL_INPUTS-1:0] crossing_q;

   logic [DATA_W-1:0] upper_level_q;
   logic [DATA_W-1:0] batt_cont_q;
   logic [DATA_W-1:0] gnd_cont_q;

   spi_state_t spi_state_q;
   logic [FRAME_BITS-1:0] rx_q;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [DATA_W-1:0] tx_q;
   logic miso_q;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_assert;
   logic cs_release;
   logic [HEADER_BITS-1:0] header;
   logic frame_write;

   logic [GND_INPUTS-1:0] gnd_wet_q;
   logic [PROG_INPUTS-1:0] prog_wet_q;
   logic [UPPER_LEVEL_BITS-1:0] upper_eff_q;
   logic [UPPER_INPUTS*CURRENT_W-1:0] upper_cur_q;

   assign pin_raw = {spi_sclk_i, spi_cs_b_i, spi_mosi_i, programmable_switch_input_cmp_i, ground_switch_input_cmp_i};

   // three-stage synchroniser, a change counts once stages two and three agree
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         sync3_q <= SYNC_RST;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_stable
         assign stable_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : stable_q[i];
      end
   endgenerate

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         stable_q <= SYNC_RST;
         crossing_q <= '0;
      end else begin
         stable_q <= stable_d;
         // any settled comparator change is a threshold crossing
         crossing_q <= stable_d[ALL_INPUTS-1:0] ^ stable_q[ALL_INPUTS-1:0]; // [RQ5]
      end
   end

   assign sclk_rise = stable_d[SYNC_SCLK] & ~stable_q[SYNC_SCLK];
   assign sclk_fall = ~stable_d[SYNC_SCLK] & stable_q[SYNC_SCLK];
   assign cs_assert = ~stable_d[SYNC_CS] & stable_q[SYNC_CS];
   assign cs_release = stable_d[SYNC_CS] & ~stable_q[SYNC_CS];
   assign header = {rx_q[HEADER_BITS-2:0], stable_d[SYNC_MOSI]};
   // a short or long frame is dropped rather than half applied
   assign frame_write = (bit_cnt_q == BIT_CNT_W'(FRAME_BITS)) && (rx_q[RW_BIT] == RW_WRITE); // [RQ1]

   // read mux, unmapped addresses and unused bits return zero
   function automatic logic [DATA_W-1:0] read_reg(input logic [ADDR_W-1:0] addr);
      case (addr)
         ADDR_UPPER_GND_LEVEL: read_reg = upper_level_q & UPPER_LEVEL_MASK; // [RQ12]
         ADDR_BATT_CONT: read_reg = batt_cont_q & BATT_CONT_MASK; // [RQ12]
         ADDR_GND_CONT: read_reg = gnd_cont_q & GND_CONT_MASK; // [RQ12]
         default: read_reg = DATA_ZERO;
      endcase
   endfunction

   // frame state: spi mode 0, msb first
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         spi_state_q <= SPI_IDLE;
         rx_q <= '0;
         bit_cnt_q <= '0;
      end else begin
         case (spi_state_q)
            SPI_IDLE: begin
               if (cs_assert) begin
                  spi_state_q <= SPI_SHIFT;
                  rx_q <= '0;
                  bit_cnt_q <= '0;
               end
            end
            SPI_SHIFT: begin
               if (cs_release) begin
                  spi_state_q <= SPI_IDLE;
               end else if (sclk_rise) begin
                  rx_q <= {rx_q[FRAME_BITS-2:0], stable_d[SYNC_MOSI]}; // [RQ1]
                  if (bit_cnt_q != BIT_CNT_W'(FRAME_BITS + 1)) begin
                     bit_cnt_q <= bit_cnt_q + 1'b1;
                  end
               end
            end
            default: spi_state_q <= SPI_IDLE;
         endcase
      end
   end

   // reply: zero header byte, then the addressed register in the same frame
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tx_q <= '0;
         miso_q <= 1'b0;
      end else if (spi_state_q == SPI_IDLE || cs_release) begin
         tx_q <= '0;
         miso_q <= 1'b0;
      end else if (sclk_rise && bit_cnt_q == BIT_CNT_W'(HEADER_BITS - 1)) begin
         tx_q <= read_reg(header[HEADER_BITS-1:1]); // [RQ1]
      end else if (sclk_fall && bit_cnt_q >= BIT_CNT_W'(HEADER_BITS)) begin
         miso_q <= tx_q[DATA_W-1];
         tx_q <= {tx_q[DATA_W-2:0], 1'b0};
      end
   end

   // register writes land at chip-select release and steer the timers at once
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         upper_level_q <= UPPER_LEVEL_RST; // [RQ4]
         batt_cont_q <= CONT_RST; // [RQ8]
         gnd_cont_q <= CONT_RST; // [RQ8]
      end else if (spi_state_q == SPI_SHIFT && cs_release && frame_write) begin
         case (rx_q[FRAME_BITS-1:ADDR_LSB])
            ADDR_UPPER_GND_LEVEL: upper_level_q <= rx_q[DATA_W-1:0] & UPPER_LEVEL_MASK; // [RQ2] [RQ11] [RQ12]
            ADDR_BATT_CONT: batt_cont_q <= rx_q[DATA_W-1:0] & BATT_CONT_MASK; // [RQ9] [RQ11] [RQ12]
            ADDR_GND_CONT: gnd_cont_q <= rx_q[DATA_W-1:0] & GND_CONT_MASK; // [RQ10] [RQ11] [RQ12]
            default: begin
            end
         endcase
      end
   end

   assign tmr_if.crossing = crossing_q;
   assign tmr_if.continuous = {batt_cont_q[PROG_INPUTS-1:0], gnd_cont_q[GND_INPUTS-1:0]}; // [RQ9] [RQ10]

   wetting_timer_bank #(
      .WET_TICKS(WETTING_TICKS)
   ) u_timers (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .tmr(tmr_if.timer)
   );

   // effective level per upper ground input: programmed or sustain
   generate
      for (i = 0; i < UPPER_INPUTS; i++) begin : g_level
         level_code_t eff;
         assign eff = tmr_if.active[UPPER_FIRST+i] ? upper_level_q[i*LEVEL_W +: LEVEL_W] : LEVEL_SUSTAIN; // [RQ6]
         always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
               upper_eff_q[i*LEVEL_W +: LEVEL_W] <= LEVEL_SUSTAIN;
               upper_cur_q[i*CURRENT_W +: CURRENT_W] <= level_to_tenths(LEVEL_SUSTAIN);
            end else begin
               upper_eff_q[i*LEVEL_W +: LEVEL_W] <= eff; // [RQ2]
               upper_cur_q[i*CURRENT_W +: CURRENT_W] <= level_to_tenths(eff); // [RQ3]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         gnd_wet_q <= '0;
         prog_wet_q <= '0;
      end else begin
         gnd_wet_q <= tmr_if.active[GND_INPUTS-1:0]; // [RQ6]
         prog_wet_q <= tmr_if.active[ALL_INPUTS-1:GND_INPUTS]; // [RQ6]
      end
   end

   assign spi_miso_o = miso_q;
   assign ground_switch_input_wetting_o = gnd_wet_q;
   assign programmable_switch_input_wetting_o = prog_wet_q;
   assign upper_ground_level_o = upper_eff_q;
   assign upper_ground_current_o = upper_cur_q;
endmodule
`default_nettype wire

// *** shared/wetting_pkg.sv ***
// constants, types and helpers shared by the wetting current configuration block
`default_nettype none
package wetting_pkg;
   // command frame layout
   localparam int FRAME_BITS = 32;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 24;
   localparam int ADDR_LSB = 25;
   localparam int RW_BIT = 24;
   localparam int HEADER_BITS = 8;
   localparam int BIT_CNT_W = 6;
   localparam logic RW_WRITE = 1'h1;

   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_UPPER_GND_LEVEL = 7'h06;
   localparam logic [ADDR_W-1:0] ADDR_BATT_CONT = 7'h0b;
   localparam logic [ADDR_W-1:0] ADDR_GND_CONT = 7'h0c;

   // implemented bits and reset values
   localparam logic [DATA_W-1:0] UPPER_LEVEL_MASK = 24'h03_ffff;
   localparam logic [DATA_W-1:0] BATT_CONT_MASK = 24'h00_00ff;
   localparam logic [DATA_W-1:0] GND_CONT_MASK = 24'h00_3fff;
   localparam logic [DATA_W-1:0] UPPER_LEVEL_RST = 24'h03_6db6;
   localparam logic [DATA_W-1:0] CONT_RST = 24'h00_0000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 24'h00_0000;

   // inputs
   localparam int GND_INPUTS = 14;
   localparam int PROG_INPUTS = 8;
   localparam int ALL_INPUTS = GND_INPUTS + PROG_INPUTS;
   localparam int UPPER_FIRST = 8;
   localparam int UPPER_INPUTS = 6;
   localparam int LEVEL_W = 3;
   localparam int UPPER_LEVEL_BITS = UPPER_INPUTS * LEVEL_W;
   localparam int CURRENT_W = 8;

   typedef logic [LEVEL_W-1:0] level_code_t;
   localparam level_code_t LEVEL_SUSTAIN = 3'h0;

   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 8;
   localparam int WETTING_TIME_MS = 20;
   localparam int WETTING_TICKS_DEF = WETTING_TIME_MS * 1000000 / TICK_NS;
   localparam int TIMER_W = 15;

   // pin synchroniser
   localparam int SYNC_W = ALL_INPUTS + 3;
   localparam int SYNC_SCLK = ALL_INPUTS + 2;
   localparam int SYNC_CS = ALL_INPUTS + 1;
   localparam int SYNC_MOSI = ALL_INPUTS;
   localparam logic [SYNC_W-1:0] SYNC_RST = 25'h080_0000;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_SHIFT = 2'b01
   } spi_state_t;

   // level code to contact current in tenths of a milliampere
   function automatic logic [CURRENT_W-1:0] level_to_tenths(input level_code_t code);
      case (code)
         3'h0: level_to_tenths = 8'h14;
         3'h1: level_to_tenths = 8'h3c;
         3'h2: level_to_tenths = 8'h50;
         3'h3: level_to_tenths = 8'h64;
         3'h4: level_to_tenths = 8'h78;
         3'h5: level_to_tenths = 8'h8c;
         3'h6: level_to_tenths = 8'ha0;
         default: level_to_tenths = 8'hc8;
      endcase
   endfunction
endpackage
`default_nettype wire

// *** shared/wetting_timer_if.sv ***
// carrier between the register logic and the per-input wetting timers
`timescale 1ns/1ns
`default_nettype none
interface wetting_timer_if;
   import wetting_pkg::*;
   logic [ALL_INPUTS-1:0] crossing;
   logic [ALL_INPUTS-1:0] continuous;
   logic [ALL_INPUTS-1:0] active;
   modport ctrl (output crossing, output continuous, input active);
   modport timer (input crossing, input continuous, output active);
endinterface
`default_nettype wire

// *** core/wetting_timer_bank.sv ***
// one wetting timer per switch input with a shared microsecond tick
`timescale 1ns/1ns
`default_nettype none
module wetting_timer_bank
   import wetting_pkg::*;
#(
   parameter int WET_TICKS = WETTING_TICKS_DEF
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   wetting_timer_if.timer tmr
);
   localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);
   // one tick beyond the length: the first tick after a start is partial, so the window never runs short
   localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WET_TICKS); // [RQ5]

   logic [TICK_CNT_W-1:0] tick_cnt_q;
   logic tick_q;

   // shared divider keeps each timer narrow
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_LAST) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   genvar i;
   generate
      for (i = 0; i < ALL_INPUTS; i++) begin : g_timer
         logic [TIMER_W-1:0] cnt_q;
         logic act_q;
         always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
               cnt_q <= '0;
               act_q <= 1'b0;
            end else if (tmr.continuous[i]) begin
               cnt_q <= '0; // [RQ7]
               act_q <= 1'b1; // [RQ7]
            end else if (tmr.crossing[i]) begin
               cnt_q <= '0; // [RQ5]
               act_q <= 1'b1; // [RQ5]
            end else if (act_q && tick_q) begin
               if (cnt_q == TIMER_LAST) begin
                  act_q <= 1'b0; // [RQ6]
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
         end
         assign tmr.active[i] = act_q;
      end
   endgenerate
endmodule
`default_nettype wire

// *** dv/wetting_chk.sv ***
// port-level assertions for the wetting current configuration block
`timescale 1ns/1ns
`default_nettype none
module wetting_chk
   import wetting_pkg::*;
#(
   parameter int WETTING_TICKS = WETTING_TICKS_DEF
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_b_i,
   input wire logic spi_miso_o,
   input wire logic [GND_INPUTS-1:0] ground_switch_input_cmp_i,
   input wire logic [GND_INPUTS-1:0] ground_switch_input_wetting_o,
   input wire logic [UPPER_LEVEL_BITS-1:0] upper_ground_level_o,
   input wire logic [UPPER_INPUTS*CURRENT_W-1:0] upper_ground_current_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   localparam int LO = WETTING_TICKS * 250;
   localparam int HI = LO + 300;
   // saturating count since input 0 last moved; starts saturated so idle is legal
   int since_q;
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         since_q <= HI + 1;
      end else if ($changed(ground_switch_input_cmp_i[0])) begin
         since_q <= 0;
      end else if (since_q <= HI) begin
         since_q <= since_q + 1;
      end
   end
   sequence s_cross;
      $changed(ground_switch_input_cmp_i[0]) ##1 $stable(ground_switch_input_cmp_i[0]) [*6];
   endsequence
   property p_reset;
      disable iff (1'b0) sys_rst_i |=> (ground_switch_input_wetting_o == '0 && upper_ground_level_o == '0 && !spi_miso_o);
   endproperty
   property p_miso_idle;
      spi_cs_b_i [*8] |-> !spi_miso_o;
   endproperty
   property p_miso_hold;
      (spi_sclk_i && !spi_cs_b_i) [*6] |-> $stable(spi_miso_o);
   endproperty
   property p_wet_rise;
      s_cross |-> ##[0:4] ground_switch_input_wetting_o[0];
   endproperty
   property p_wet_min;
      (since_q >= 12 && since_q <= LO) |-> ground_switch_input_wetting_o[0];
   endproperty
   property p_wet_max;
      since_q > HI |-> !ground_switch_input_wetting_o[0];
   endproperty
   property p_sustain_code;
      !ground_switch_input_wetting_o[8] |-> upper_ground_level_o[2:0] == 3'h0;
   endproperty
   property p_current;
      upper_ground_level_o[2:0] inside {3'h0, 3'h7} |->
         upper_ground_current_o[7:0] == (upper_ground_level_o[2:0] == 3'h0 ? 8'h14 : 8'hc8);
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   a_miso_idle: assert property (p_miso_idle) else $error("miso high outside frame");
   a_miso_hold: assert property (p_miso_hold) else $error("miso moved while sclk high");
   a_wet_rise: assert property (p_wet_rise) else $error("wetting late after crossing");
   a_wet_min: assert property (p_wet_min) else $error("wetting dropped early");
   a_wet_max: assert property (p_wet_max) else $error("wetting held too long");
   a_sustain_code: assert property (p_sustain_code) else $error("level code not sustain");
   a_current: assert property (p_current) else $error("current does not match code");
endmodule
bind wetting_current_config wetting_chk #(.WETTING_TICKS(WETTING_TICKS)) chk (
   .clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i),
   .spi_sclk_i(spi_sclk_i),
   .spi_cs_b_i(spi_cs_b_i),
   .spi_miso_o(spi_miso_o),
   .ground_switch_input_cmp_i(ground_switch_input_cmp_i),
   .ground_switch_input_wetting_o(ground_switch_input_wetting_o),
   .upper_ground_level_o(upper_ground_level_o),
   .upper_ground_current_o(upper_ground_current_o)
);
`default_nettype wire

// *** dv/spi_host_model.sv ***
// spi mode 0 host that sends 32-bit command frames
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   input wire logic clk_sys_i,
   input wire logic spi_miso_i,
   output logic spi_sclk_o,
   output logic spi_cs_b_o,
   output logic spi_mosi_o
);
   initial begin
      spi_sclk_o = 1'b0;
      spi_cs_b_o = 1'b1;
      spi_mosi_o = 1'b0;
   end
   // half period of 8 clocks, above the slave's minimum
   task automatic half();
      repeat (8) @(posedge clk_sys_i);
      #1;
   endtask
   // fewer than 32 bits makes a deliberately short frame
   task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [23:0] rdata);
      logic [31:0] sh;
      sh = 32'h0000_0000;
      spi_cs_b_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         spi_mosi_o = cmd[31-i];
         half();
         sh = {sh[30:0], spi_miso_i};
         spi_sclk_o = 1'b1;
         half();
         spi_sclk_o = 1'b0;
      end
      half();
      spi_cs_b_o = 1'b1;
      // released data line must not keep its last value
      spi_mosi_o = ~spi_mosi_o;
      half();
      rdata = sh[23:0];
   endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the wetting current configuration block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import wetting_pkg::*;
   localparam int WT = 4;
   localparam logic [ADDR_W-1:0] ADDR_NONE = 7'h0a;
   logic clk_sys_i;
   logic sys_rst_i;
   logic sclk, cs_b, mosi, miso;
   logic [GND_INPUTS-1:0] gnd_cmp, gnd_wet;
   logic [PROG_INPUTS-1:0] prog_cmp, prog_wet;
   logic [UPPER_LEVEL_BITS-1:0] level;
   logic [UPPER_INPUTS*CURRENT_W-1:0] current;
   logic [7:0] tenths [8] = '{8'h14, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h8c, 8'ha0, 8'hc8};
   int miscompares = 0;
   int comparisons = 0;
   wetting_current_config #(.WETTING_TICKS(WT)) DUT (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk), .spi_cs_b_i(cs_b),
      .spi_mosi_i(mosi), .spi_miso_o(miso), .ground_switch_input_cmp_i(gnd_cmp),
      .programmable_switch_input_cmp_i(prog_cmp), .ground_switch_input_wetting_o(gnd_wet),
      .programmable_switch_input_wetting_o(prog_wet), .upper_ground_level_o(level),
      .upper_ground_current_o(current));
   spi_host_model host (.clk_sys_i(clk_sys_i), .spi_miso_i(miso), .spi_sclk_o(sclk),
      .spi_cs_b_o(cs_b), .spi_mosi_o(mosi));
   task automatic stop_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic [DATA_W-1:0] r;
      host.xfer({a, RW_WRITE, d}, 32, r);
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] r;
      host.xfer({a, ~RW_WRITE, DATA_ZERO}, 32, r);
      check(r, exp);
   endtask
   task automatic wait_wet(input logic want, output int n);
      n = 0;
      while (gnd_wet[0] !== want && n < 2000) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
   endtask
   task automatic t_reset();
      check({prog_wet, gnd_wet, level}, '0);
      check(current, {6{8'h14}});
      rd_chk(ADDR_UPPER_GND_LEVEL, {6'h00, {6{3'h6}}});
      rd_chk(ADDR_BATT_CONT, 24'h00_0000);
      rd_chk(ADDR_GND_CONT, 24'h00_0000);
   endtask
   task automatic t_regs();
      logic [DATA_W-1:0] r;
      wr(ADDR_UPPER_GND_LEVEL, 24'hff_ffff);
      wr(ADDR_BATT_CONT, 24'hff_fff0);
      wr(ADDR_GND_CONT, 24'hff_ff00);
      wr(ADDR_NONE, 24'hff_ffff);
      rd_chk(ADDR_UPPER_GND_LEVEL, 24'h03_ffff);
      rd_chk(ADDR_BATT_CONT, 24'h00_00f0);
      rd_chk(ADDR_GND_CONT, 24'h00_3f00);
      rd_chk(ADDR_NONE, 24'h00_0000);
      host.xfer({ADDR_UPPER_GND_LEVEL, RW_WRITE, DATA_ZERO}, 31, r);
      rd_chk(ADDR_UPPER_GND_LEVEL, 24'h03_ffff);
   endtask
   task automatic t_levels();
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_UPPER_GND_LEVEL, {6'h00, {6{c[2:0]}}});
         repeat (4) @(posedge clk_sys_i);
         #1;
         check(level, {6{c[2:0]}});
         check(current, {6{tenths[c]}});
         check({prog_wet[7:4], gnd_wet[13:8]}, 10'h3ff);
      end
   endtask
   task automatic t_pulse();
      int n;
      wr(ADDR_BATT_CONT, DATA_ZERO);
      wr(ADDR_GND_CONT, DATA_ZERO);
      gnd_cmp[0] = 1'b1;
      prog_cmp[0] = 1'b1;
      wait_wet(1'b1, n);
      check(n < 20, 1'b1);
      repeat (2) @(posedge clk_sys_i);
      #1;
      check(prog_wet[0], 1'b1);
      wait_wet(1'b0, n);
      check(n >= WT * 250 - 4 && n <= WT * 250 + 254, 1'b1);
      repeat (300) @(posedge clk_sys_i);
      #1;
      check({prog_wet, gnd_wet, level}, '0);
      check(current, {6{8'h14}});
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      sys_rst_i = 1'b1;
      gnd_cmp = '0;
      prog_cmp = '0;
      repeat (4) @(posedge clk_sys_i);
      #1;
      sys_rst_i = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
      t_reset();
      t_regs();
      t_levels();
      t_pulse();
      stop_test();
   end
   // the whole run needs about 55 us
   initial begin
      #200_000;
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire
